/* inc/svi_cfg.svh */
// Purpose: register map, field positions and reset values of the interrupt unit
// Assumes: AXI4-Lite, 32-bit data, byte addresses
// Notes: request byte offset and mask byte offset are not multiples of four,
//        so they are kept as indices and the byte address is four times the index
// Notes on behaviour
// (R1) six requests: four port pins, two timers
// (R2) mask register: global enable plus per-source enables
// (R3) twelve low program bytes hold six vectors
// (R4) vector pair at two times source index
// (R5) software-set priority order picks pending request
// (R6) grant disables interrupts, saves state, branches
// (R7) masked requests still latched for polling
// (R8) comparator one onto c, two onto a
// (R9) request bits 7,6 select pin1/pin2 edges
// (R10) int_req_b only on pin3 falling edge
// (R11) timer end of count sets e, f
// (R12) software reads pin levels
// (R13) pin0, pin3 falling only; pin1, pin2 programmable
// (R14) grant clears served pending bit
// (R15) pending stays latched until served or cleared
`ifndef SVI_CFG_SVH
`define SVI_CFG_SVH
`define SVI_IDX_REQ 8'hFA
`define SVI_IDX_MASK 8'hFB
`define SVI_ADDR_REQ 12'h3E8
`define SVI_ADDR_MASK 12'h3EC
`define SVI_ADDR_PRIO 12'h000
`define SVI_ADDR_CTRL 12'h004
`define SVI_ADDR_PINS 12'h008
`define SVI_ADDR_VEC 12'h00C
`define SVI_ADDR_IST 12'h010
`define SVI_ADDR_IEN 12'h014
`define SVI_MASK_GLOBAL 7
`define SVI_EDGE_HI 7
`define SVI_EDGE_LO 6
`define SVI_VEC_BYTES 12
`define SVI_RST_REQ 8'h00
`define SVI_RST_MASK 8'h00
`define SVI_RST_PRIO 8'h00
`endif

/* inc/svi_pkg.sv */
// Purpose: types of the interrupt unit
// Assumes: nothing
// Notes: source order a..f matches vector order
package svi_pkg;
  typedef enum logic [2:0] {
    SVI_ST_IDLE = 3'b001,
    SVI_ST_SAVE = 3'b010,
    SVI_ST_FETCH = 3'b100
  } svi_state_t;
  typedef logic [5:0] svi_src_t;
endpackage : svi_pkg

/* design/svi_unit.sv */
// Purpose: six-source vectored interrupt unit with AXI4-Lite registers
// Assumes: pins and timer pulses are synchronous to clk
// Notes: program memory read port supplies vector bytes
`timescale 1ns/10ps
`default_nettype none
`include "svi_cfg.svh"
module svi_unit (
  input wire logic clk, // system clock 100 MHz
  input wire logic rst, // async reset, active high
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire logic port3_pin0, // external request pin
  input wire logic port3_pin1, // external request pin
  input wire logic port3_pin2, // external request pin
  input wire logic port3_pin3, // external request pin
  input wire logic comparator_in_one, // comparator one output
  input wire logic comparator_in_two, // comparator two output
  input wire logic analog_mode, // comparators replace pin1/pin2
  input wire logic timer_zero, // timer zero end of count pulse
  input wire logic timer_one, // timer one end of count pulse
  input wire logic cpuAck, // core ready to take interrupt
  output logic [11:0] vecAddr, // program memory byte address
  output logic vecRead, // program memory read strobe
  input wire logic [7:0] vecData, // program memory byte, next cycle
  output logic saveState, // pulse: core pushes pc and flags
  output logic branchValid, // pulse: branch to branchAddr
  output logic [15:0] branchAddr, // service routine start
  output logic intBusy, // interrupt machine cycle running
  output logic irq // level, unmasked status bit set
);
  logic [7:0] reqReg; // request flags, bits 7:6 edge select
  logic [7:0] maskReg; // bit 7 global, 5:0 per source
  logic [7:0] prioReg; // priority select
  logic [5:0] intStat; // sticky event status
  logic [5:0] intEn; // status mask
  logic [3:0] pinPrev;
  logic swGlobalOff; // set by machine cycle, cleared by software
  svi_pkg::svi_state_t state;
  logic [2:0] grantIdx;
  logic [1:0] fetchCnt;
  logic [5:0] rawEvt, grantOh, clrReq;
  logic pinA, pinC;
  logic wrHit, rdHit;
  logic [11:0] awLat, arLat;
  logic awHave, wHave;
  logic [31:0] wLat;

  // pick source order from priority register: rotate start point
  function automatic logic [2:0] svi_pick(input logic [5:0] pend, input logic [7:0] pr);
    logic [2:0] start;
    logic [2:0] k;
    logic [2:0] res;
    int s; // unwrapped rotation position
    start = (pr[2:0] > 3'h5) ? 3'h0 : pr[2:0];
    res = 3'h7;
    // lowest rotation step wins; int sum avoids a 3-bit wrap past source 7
    for (int i = 5; i >= 0; i--) begin
      s = int'(start) + i;
      k = (s > 5) ? 3'(s - 6) : 3'(s);
      if (pend[k]) begin
        res = k;
      end
    end
    return res;
  endfunction : svi_pick

  // comparators take over pin1/pin2 in analog mode
  assign pinC = analog_mode ? comparator_in_one : port3_pin1; // R8
  assign pinA = analog_mode ? comparator_in_two : port3_pin2; // R8

  // edge detection per pin source; timer pulses need none
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinPrev <= 4'h0;
    end else begin
      pinPrev <= {port3_pin0, pinC, pinA, port3_pin3};
    end
  end

  // pinPrev resets low and edge select resets to falling, so no false event after reset
  always_comb begin
    rawEvt = 6'h00;
    // a: pin2 path, rising when bit6 set, falling otherwise, both on 11
    case (reqReg[`SVI_EDGE_HI:`SVI_EDGE_LO]) // R9
      2'b00: begin
        rawEvt[2] = pinPrev[2] & ~pinC;
        rawEvt[0] = pinPrev[1] & ~pinA;
      end
      2'b01: begin
        rawEvt[2] = pinPrev[2] & ~pinC;
        rawEvt[0] = ~pinPrev[1] & pinA;
      end
      2'b10: begin
        rawEvt[2] = ~pinPrev[2] & pinC;
        rawEvt[0] = pinPrev[1] & ~pinA;
      end
      default: begin
        rawEvt[2] = pinPrev[2] ^ pinC;
        rawEvt[0] = pinPrev[1] ^ pinA;
      end
    endcase
    rawEvt[1] = pinPrev[0] & ~port3_pin3; // R10 R13
    rawEvt[3] = pinPrev[3] & ~port3_pin0; // R13 R1
    rawEvt[4] = timer_zero; // R11
    rawEvt[5] = timer_one; // R11
  end

  // bus write decode
  assign s_axi_awready = ~awHave;
  assign s_axi_wready = ~wHave;
  assign wrHit = awHave & wHave & ~s_axi_bvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awLat <= 12'h000;
      wLat <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid & ~awHave) begin
        awHave <= 1'b1;
        awLat <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~wHave) begin
        wHave <= 1'b1;
        wLat <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      if (wrHit) begin
        awHave <= 1'b0;
        wHave <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awLat == `SVI_ADDR_REQ || awLat == `SVI_ADDR_MASK || awLat == `SVI_ADDR_PRIO ||
                        awLat == `SVI_ADDR_CTRL || awLat == `SVI_ADDR_IST || awLat == `SVI_ADDR_IEN) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // request flags: events latch regardless of mask, set beats clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reqReg <= `SVI_RST_REQ;
    end else begin
      if (wrHit && awLat == `SVI_ADDR_REQ) begin
        reqReg <= (wLat[7:0] & ~{2'b00, clrReq}) | {2'b00, rawEvt}; // R7 R15
      end else begin
        reqReg <= (reqReg & ~{2'b00, clrReq}) | {2'b00, rawEvt}; // R7 R15 R14
      end
    end
  end

  // mask, priority, status and enable registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      maskReg <= `SVI_RST_MASK;
      prioReg <= `SVI_RST_PRIO;
      intStat <= 6'h00;
      intEn <= 6'h00;
      swGlobalOff <= 1'b0;
    end else begin
      if (wrHit && awLat == `SVI_ADDR_MASK) begin
        maskReg <= wLat[7:0];
      end
      if (wrHit && awLat == `SVI_ADDR_PRIO) begin
        prioReg <= wLat[7:0]; // R5
      end
      if (wrHit && awLat == `SVI_ADDR_IEN) begin
        intEn <= wLat[5:0];
      end
      // write one to clear; a new event wins
      intStat <= (intStat & ~((wrHit && awLat == `SVI_ADDR_IST) ? wLat[5:0] : 6'h00)) | rawEvt;
      // grant disables further interrupts until software re-enables
      if (state == svi_pkg::SVI_ST_SAVE) begin
        swGlobalOff <= 1'b1; // R6
      end else if (wrHit && awLat == `SVI_ADDR_CTRL && wLat[0]) begin
        swGlobalOff <= 1'b0;
      end
    end
  end

  // level output, stays high until software clears the status bit
  assign irq = |(intStat & intEn);

  // grant path: pending, enabled, globally on
  logic [5:0] eligible;
  assign eligible = reqReg[5:0] & maskReg[5:0] & {6{maskReg[`SVI_MASK_GLOBAL] & ~swGlobalOff}}; // R2
  assign grantOh = (svi_pick(eligible, prioReg) == 3'h7) ? 6'h00 : 6'(6'h01 << svi_pick(eligible, prioReg)); // R5
  assign clrReq = (state == svi_pkg::SVI_ST_IDLE && cpuAck) ? grantOh : 6'h00; // R14

  // interrupt machine cycle: save, then fetch two vector bytes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= svi_pkg::SVI_ST_IDLE;
      grantIdx <= 3'h0;
      fetchCnt <= 2'h0;
      branchAddr <= 16'h0000;
      branchValid <= 1'b0;
      saveState <= 1'b0;
    end else begin
      branchValid <= 1'b0;
      saveState <= 1'b0;
      case (state)
        svi_pkg::SVI_ST_IDLE: begin
          // the core's ack gates the grant so no instruction is cut short
          if (cpuAck && grantOh != 6'h00) begin
            grantIdx <= svi_pick(eligible, prioReg);
            state <= svi_pkg::SVI_ST_SAVE;
            saveState <= 1'b1; // R6
          end
        end
        svi_pkg::SVI_ST_SAVE: begin
          fetchCnt <= 2'h0;
          state <= svi_pkg::SVI_ST_FETCH;
        end
        svi_pkg::SVI_ST_FETCH: begin
          // each byte arrives one cycle after its address
          fetchCnt <= 2'(fetchCnt + 2'h1);
          if (fetchCnt == 2'h1) begin
            branchAddr[15:8] <= vecData; // R4
          end
          if (fetchCnt == 2'h2) begin
            branchAddr[7:0] <= vecData; // R4
            branchValid <= 1'b1; // R6
            state <= svi_pkg::SVI_ST_IDLE;
          end
        end
        default: state <= svi_pkg::SVI_ST_IDLE;
      endcase
    end
  end

  // vector byte pair 2n, 2n+1 inside the reserved 12 bytes
  assign vecRead = (state == svi_pkg::SVI_ST_FETCH) && (fetchCnt != 2'h2);
  assign vecAddr = {8'h00, grantIdx, fetchCnt[0]}; // R3 R4
  assign intBusy = (state != svi_pkg::SVI_ST_IDLE);

  // read channel
  assign s_axi_arready = ~s_axi_rvalid & ~rdHit;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdHit <= 1'b0;
      arLat <= 12'h000;
    end else begin
      rdHit <= s_axi_arvalid & s_axi_arready;
      if (s_axi_arvalid & s_axi_arready) begin
        arLat <= s_axi_araddr;
      end
    end
  end

  // read data registered; unmapped offsets read zero with an error response
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (rdHit) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      if (arLat == `SVI_ADDR_REQ) begin
        s_axi_rdata <= {24'h000000, reqReg}; // R7
      end else if (arLat == `SVI_ADDR_MASK) begin
        s_axi_rdata <= {24'h000000, maskReg};
      end else if (arLat == `SVI_ADDR_PRIO) begin
        s_axi_rdata <= {24'h000000, prioReg};
      end else if (arLat == `SVI_ADDR_CTRL) begin
        s_axi_rdata <= {27'h0000000, intBusy, 3'h0, swGlobalOff};
      end else if (arLat == `SVI_ADDR_PINS) begin
        s_axi_rdata <= {26'h0000000, pinC, pinA, port3_pin3, port3_pin2, port3_pin1, port3_pin0}; // R12
      end else if (arLat == `SVI_ADDR_VEC) begin
        s_axi_rdata <= {16'h0000, branchAddr};
      end else if (arLat == `SVI_ADDR_IST) begin
        s_axi_rdata <= {26'h0000000, intStat};
      end else if (arLat == `SVI_ADDR_IEN) begin
        s_axi_rdata <= {26'h0000000, intEn};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'b10;
      end
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : svi_unit
`default_nettype wire

/* bench/svi_unit_props.sv */
// Purpose: port assertions of the interrupt unit
// Assumes: one clock, async reset active high
// Notes: grant timing follows the hand-over walk
`timescale 1ns/10ps
`default_nettype none
module svi_unit_props (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic cpuAck, // core ack
  input wire logic [11:0] vecAddr, // vector address
  input wire logic vecRead, // vector strobe
  input wire logic [7:0] vecData, // vector byte
  input wire logic saveState, // save pulse
  input wire logic branchValid, // branch pulse
  input wire logic [15:0] branchAddr, // branch target
  input wire logic intBusy // cycle running
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // even table byte first, its odd partner next
  sequence fetch_even;
    vecRead && !vecAddr[0] && vecAddr < 12'h00C;
  endsequence
  sequence fetch_odd;
    vecAddr == $past(vecAddr) + 12'h001;
  endsequence
  grant_ack_a: assert property ($rose(saveState) |-> $past(cpuAck))
    else $error("grant without ack");
  save_once_a: assert property (saveState |=> (!saveState) [*4])
    else $error("second save pulse");
  vec_pair_a: assert property (saveState |=> fetch_even ##1 fetch_odd)
    else $error("bad vector fetch");
  branch_time_a: assert property (saveState |-> ##4 branchValid)
    else $error("branch not on time");
  branch_addr_a: assert property (branchValid |-> branchAddr == {$past(vecData, 2), $past(vecData)})
    else $error("branch target wrong");
  busy_span_a: assert property (saveState |-> intBusy [*3])
    else $error("busy dropped early");
  // one read at a time; a slow answer would stall software polling
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
endmodule : svi_unit_props
`default_nettype wire

/* bench/svi_mem_model.sv */
// Purpose: program memory holding the vector table
// Assumes: byte answered one cycle after the strobe
// Notes: byte n holds C0+n; idle bus scrambles
`timescale 1ns/10ps
`default_nettype none
module svi_mem_model (
  input wire logic clk, // clock
  input wire logic [11:0] vecAddr, // byte address
  input wire logic vecRead, // read strobe
  output logic [7:0] vecData // byte, next cycle
);
  initial vecData = 8'h5A;
  // stale data inverted so a late sample cannot pass
  always @(posedge clk) begin
    vecData <= vecRead ? 8'hC0 + vecAddr[7:0] : ~vecData;
  end
endmodule : svi_mem_model
`default_nettype wire

/* bench/svi_unit_tb.sv */
// Purpose: self-checking bench of the interrupt unit
// Assumes: register map of svi_cfg.svh
// Notes: pins idle high; edge cases in a table
`timescale 1ns/10ps
`default_nettype none
`include "svi_cfg.svh"
module svi_unit_tb;
  logic clk = 1'b0, rst = 1'b1, analog_mode = 1'b0, timer_zero = 1'b0, timer_one = 1'b0, cpuAck = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, vecRead, saveState, branchValid;
  logic intBusy, irq;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, vecAddr;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd32;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] vecData;
  logic [15:0] branchAddr;
  logic [5:0] lv = 6'h3F; // cmp2, cmp1, pin3..pin0
  wire port3_pin0 = lv[0], port3_pin1 = lv[1], port3_pin2 = lv[2], port3_pin3 = lv[3];
  wire comparator_in_one = lv[4], comparator_in_two = lv[5];
  int nMismatch = 0, cmpCount = 0;
  // edge select, source, rising, expected request bits
  logic [11:0] rows [17] = '{
    {2'd0, 3'd1, 1'b0, 6'h04}, {2'd0, 3'd1, 1'b1, 6'h00}, {2'd0, 3'd2, 1'b0, 6'h01}, {2'd1, 3'd2, 1'b1, 6'h01},
    {2'd1, 3'd2, 1'b0, 6'h00}, {2'd1, 3'd1, 1'b0, 6'h04}, {2'd2, 3'd1, 1'b1, 6'h04}, {2'd2, 3'd1, 1'b0, 6'h00},
    {2'd2, 3'd2, 1'b0, 6'h01}, {2'd3, 3'd1, 1'b1, 6'h04}, {2'd3, 3'd2, 1'b0, 6'h01}, {2'd0, 3'd0, 1'b0, 6'h08},
    {2'd0, 3'd0, 1'b1, 6'h00}, {2'd0, 3'd3, 1'b0, 6'h02}, {2'd0, 3'd3, 1'b1, 6'h00}, {2'd0, 3'd4, 1'b0, 6'h04},
    {2'd0, 3'd5, 1'b0, 6'h01}};
  always #5 clk = ~clk;
  svi_unit svi_unit_inst (.*);
  svi_mem_model svi_mem_model_inst (.*);
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    cmpCount++;
    if (g !== e) begin
      nMismatch++;
      $display("ERROR at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk
  // aw and w offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd32 = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic req_is(input logic [7:0] e);
    rd(`SVI_ADDR_REQ);
    chk({24'h0, e}, rd32);
  endtask : req_is
  task automatic irq_is(input logic e);
    @(negedge clk);
    chk({31'h0, e}, {31'h0, irq});
  endtask : irq_is
  task automatic tick(input logic [1:0] t);
    @(posedge clk);
    timer_zero <= t[0];
    timer_one <= t[1];
    @(posedge clk);
    timer_zero <= 1'b0;
    timer_one <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : tick
  // the core allows a grant until the branch is seen
  task automatic grant(input logic [15:0] e);
    @(posedge clk);
    cpuAck <= 1'b1;
    do @(negedge clk); while (!branchValid);
    chk({16'h0, e}, {16'h0, branchAddr});
    @(posedge clk);
    cpuAck <= 1'b0;
  endtask : grant
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  // the run needs a few hundred cycles; far beyond means a hang
  initial begin
    #300000;
    nMismatch++;
    results();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    req_is(8'h00);
    rd(`SVI_ADDR_MASK);
    chk(32'h0, rd32);
    rd(12'h100);
    chk(32'h2, {30'h0, resp});
    chk(32'h0, rd32);
    wr(12'h100, 32'h0);
    chk(32'h2, {30'h0, resp});
    // start level settles, request clears, then the edge
    foreach (rows[i]) begin
      @(posedge clk);
      analog_mode <= rows[i][9:7] > 3'd3;
      lv[rows[i][9:7]] <= ~rows[i][6];
      repeat (3) @(posedge clk);
      wr(`SVI_ADDR_REQ, {24'h0, rows[i][11:10], 6'h00});
      @(posedge clk);
      lv[rows[i][9:7]] <= rows[i][6];
      repeat (3) @(posedge clk);
      req_is({rows[i][11:10], rows[i][5:0]});
      lv <= 6'h3F;
    end
    @(posedge clk);
    analog_mode <= 1'b0;
    lv <= 6'h35;
    repeat (3) @(posedge clk);
    rd(`SVI_ADDR_PINS);
    chk(32'h15, rd32);
    lv <= 6'h3F;
    wr(`SVI_ADDR_REQ, 32'h0);
    wr(`SVI_ADDR_IST, 32'hFF);
    tick(2'b11);
    req_is(8'h30);
    irq_is(1'b0);
    wr(`SVI_ADDR_IEN, 32'h10);
    chk(32'h0, {30'h0, resp});
    irq_is(1'b1);
    wr(`SVI_ADDR_IST, 32'h10);
    irq_is(1'b0);
    wr(`SVI_ADDR_PRIO, 32'h5);
    wr(`SVI_ADDR_MASK, 32'h3F);
    @(posedge clk);
    cpuAck <= 1'b1;
    repeat (10) @(posedge clk);
    cpuAck <= 1'b0;
    req_is(8'h30);
    wr(`SVI_ADDR_MASK, 32'h90);
    grant(16'hC8C9);
    req_is(8'h20);
    wr(`SVI_ADDR_CTRL, 32'h1);
    tick(2'b01);
    wr(`SVI_ADDR_MASK, 32'hBF);
    grant(16'hCACB);
    req_is(8'h10);
    wr(`SVI_ADDR_CTRL, 32'h1);
    grant(16'hC8C9);
    req_is(8'h00);
    // reset in mid-run returns mask and priority to their reset values
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`SVI_ADDR_MASK);
    chk(32'h0, rd32);
    rd(`SVI_ADDR_PRIO);
    chk(32'h0, rd32);
    results();
  end
endmodule : svi_unit_tb
bind svi_unit svi_unit_props svi_unit_props_inst (.*);
`default_nettype wire
